/* inc/sxb_pkg.sv */
// Constants, register map and types shared by the stream crossbar switch
// Function
// - Only stream transfers pass; no memory-mapped transactions are handled.
// - Valid and ready always exist; other sideband is optional, widths are parameters.
// - Strobe and keep carry one bit per data byte.
// - Each port has its own active-low reset beside the shared clock.
// - An optional per-port clock enable gates that port's handshakes.
// - Full crossbar, one to sixteen inputs and outputs, arbitrated per output.
// - A transfer goes to the output whose low-high range holds its destination.
// - Arbitration is round-robin or fixed priority, chosen by configuration.
// - A stalled grant holder is dropped so others are not blocked.
// - Native datapath width is any whole byte count up to 4096 bits.
// - Grants end at packet end, after a transfer count, or after idle cycles.
// - Optional register stages sit before the decoder and after the arbiter.
// - A connectivity map decides which inputs may reach which outputs.
// - Port widths are byte multiples; here they equal the native width.
// - Integer-ratio slower ports are served through their clock enables.
// - Unrelated clocks need an external asynchronous converter; none is built in.
// - A register slice adds one cycle and keeps full throughput.
// - Input FIFOs have power-of-two depth from 16 to 32768.
// - Packet mode holds a packet until its last transfer is stored.
// - Each FIFO reports its occupancy as a data count.
// - Error flags for decode miss, sparse keep and packer error.
package sxb_pkg;

  // ==========================================================================
  // Register map, byte addresses
  localparam int unsigned SXB_AW             = 10;
  localparam logic [9:0]  SXB_REG_CTRL       = 10'h000;
  localparam logic [9:0]  SXB_REG_ARB_CNT    = 10'h004;
  localparam logic [9:0]  SXB_REG_ARB_IDLE   = 10'h008;
  localparam logic [9:0]  SXB_REG_ERR        = 10'h00c;
  localparam logic [9:0]  SXB_REG_ROUTE_BASE = 10'h040;
  localparam logic [9:0]  SXB_REG_FCNT_BASE  = 10'h200;
  localparam logic [1:0]  SXB_ROUTE_LO       = 2'h0;
  localparam logic [1:0]  SXB_ROUTE_HI       = 2'h1;
  localparam logic [1:0]  SXB_ROUTE_CONN     = 2'h2;

  // ==========================================================================
  // Fields and reset values
  localparam int unsigned SXB_CTRL_PRIO      = 0;
  localparam int unsigned SXB_CTRL_PKT       = 1;
  localparam int unsigned SXB_CTRL_LAST      = 2;
  localparam logic [31:0] SXB_CTRL_RST       = 32'h0000_0004;
  localparam int unsigned SXB_CNTW           = 16;
  localparam logic [15:0] SXB_ARB_CNT_RST    = 16'h0000;
  localparam logic [15:0] SXB_ARB_IDLE_RST   = 16'h0010;
  localparam int unsigned SXB_ERR_MISS       = 0;
  localparam int unsigned SXB_ERR_SPARSE     = 1;
  localparam int unsigned SXB_ERR_PACK       = 2;
  localparam int unsigned SXB_ERRW           = 3;

  // ==========================================================================
  // Per-output arbiter state
  typedef enum logic [1:0] {
    SXB_ARB_IDLE = 2'b01,
    SXB_ARB_HOLD = 2'b10
  } sxb_arb_t;

endpackage : sxb_pkg

/* rtl/sxb_slice.sv */
// Two-entry register slice for one stream channel
`timescale 1ns/10ps
`default_nettype none
module sxb_slice #(
  parameter int unsigned W  = 8,
  parameter bit          EN = 1'b1
) (
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  import sxb_pkg::*;

  // ==========================================================================
  // Skid buffer
  logic [W-1:0] main_q;
  logic [W-1:0] skid_q;
  logic         mv_q;
  logic         sv_q;

  generate
    if (EN) begin : g_reg
      // Skid entry lets in_ready be a flop, so no ready path runs through
      assign in_ready  = ~sv_q;
      assign out_valid = mv_q;
      assign out_data  = main_q;
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          main_q <= '0;
          skid_q <= '0;
          mv_q   <= 1'b0;
          sv_q   <= 1'b0;
        end else if (flush) begin
          mv_q <= 1'b0;
          sv_q <= 1'b0;
        end else if (out_ready || !mv_q) begin
          if (sv_q) begin
            main_q <= skid_q;
            sv_q   <= 1'b0;
          end else begin
            main_q <= in_data;
            mv_q   <= in_valid;
          end
        end else if (in_valid && !sv_q) begin
          skid_q <= in_data;
          sv_q   <= 1'b1;
        end
      end
    end else begin : g_pass
      assign in_ready  = out_ready;
      assign out_valid = in_valid;
      assign out_data  = in_data;
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          main_q <= '0;
          skid_q <= '0;
          mv_q   <= 1'b0;
          sv_q   <= 1'b0;
        end
      end
    end
  endgenerate

endmodule : sxb_slice
`default_nettype wire

/* rtl/sxb_switch.sv */
// Stream crossbar switch with input FIFOs, range decode and per-output arbiters
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module sxb_switch #(
  parameter int unsigned N_IN       = 4,
  parameter int unsigned N_OUT      = 4,
  parameter int unsigned DW         = 32,
  parameter int unsigned DESTW      = 4,
  parameter int unsigned IDW        = 4,
  parameter int unsigned UW         = 4,
  parameter int unsigned FIFO_DEPTH = 16,
  parameter bit          REG_IN     = 1'b1,
  parameter bit          REG_OUT    = 1'b1
) (
  input  wire logic                        ref_clk,
  input  wire logic                        reset,
  // Register bus
  input  wire logic [sxb_pkg::SXB_AW-1:0]  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic [31:0]                      avs_readdata,
  output logic                             avs_waitrequest,
  // Input ports
  input  wire logic [N_IN-1:0]             s_aresetn,
  input  wire logic [N_IN-1:0]             s_aclken,
  input  wire logic [N_IN-1:0]             s_tvalid,
  output logic [N_IN-1:0]                  s_tready,
  input  wire logic [N_IN*DW-1:0]          s_tdata,
  input  wire logic [N_IN*DW/8-1:0]        s_tstrb,
  input  wire logic [N_IN*DW/8-1:0]        s_tkeep,
  input  wire logic [N_IN-1:0]             s_tlast,
  input  wire logic [N_IN*DESTW-1:0]       s_tdest,
  input  wire logic [N_IN*IDW-1:0]         s_tid,
  input  wire logic [N_IN*UW-1:0]          s_tuser,
  // Output ports
  input  wire logic [N_OUT-1:0]            m_aresetn,
  input  wire logic [N_OUT-1:0]            m_aclken,
  output logic [N_OUT-1:0]                 m_tvalid,
  input  wire logic [N_OUT-1:0]            m_tready,
  output logic [N_OUT*DW-1:0]              m_tdata,
  output logic [N_OUT*DW/8-1:0]            m_tstrb,
  output logic [N_OUT*DW/8-1:0]            m_tkeep,
  output logic [N_OUT-1:0]                 m_tlast,
  output logic [N_OUT*DESTW-1:0]           m_tdest,
  output logic [N_OUT*IDW-1:0]             m_tid,
  output logic [N_OUT*UW-1:0]              m_tuser,
  // Status
  output logic [sxb_pkg::SXB_ERRW-1:0]     err_flags,
  output logic [N_IN*($clog2(FIFO_DEPTH)+1)-1:0] fifo_count
);
  import sxb_pkg::*;

  // ==========================================================================
  // Payload layout
  localparam int unsigned KW     = DW / 8;
  localparam int unsigned P_STRB = DW;
  localparam int unsigned P_KEEP = P_STRB + KW;
  localparam int unsigned P_DEST = P_KEEP + KW;
  localparam int unsigned P_ID   = P_DEST + DESTW;
  localparam int unsigned P_USER = P_ID + IDW;
  localparam int unsigned P_LAST = P_USER + UW;
  localparam int unsigned PW     = P_LAST + 1;
  localparam int unsigned FAW    = $clog2(FIFO_DEPTH);
  localparam int unsigned OIW    = (N_IN > 1) ? $clog2(N_IN) : 1;

  // Next requester after last, or lowest index in priority mode
  function automatic logic [OIW-1:0] pick(input logic [N_IN-1:0] req,
                                          input logic [OIW-1:0]  last,
                                          input logic            prio);
    logic [OIW-1:0] r;
    logic           f;
    int             idx;
    r = '0;
    f = 1'b0;
    for (int k = 0; k < N_IN; k++) begin
      idx = prio ? k : (int'(last) + 1 + k) % N_IN;
      if (!f && req[idx]) begin
        r = OIW'(idx);
        f = 1'b1;
      end
    end
    return r;
  endfunction : pick

  // Keep must be a run of ones from byte 0 upward
  function automatic logic keep_sparse(input logic [KW-1:0] k);
    return ((k + KW'(1)) & k) != '0;
  endfunction : keep_sparse

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction : be_merge

  // ==========================================================================
  // Register bus slave, one wait state on every access
  logic                          ack_q;
  logic [31:0]                   rd_q;
  logic [31:0]                   rd_d;
  logic [31:0]                   ctrl_q;
  logic [SXB_CNTW-1:0]           cnt_lim_q;
  logic [SXB_CNTW-1:0]           idle_lim_q;
  logic [SXB_ERRW-1:0]           err_q;
  logic [SXB_ERRW-1:0]           err_set;
  logic [N_OUT-1:0][DESTW-1:0]   lo_q;
  logic [N_OUT-1:0][DESTW-1:0]   hi_q;
  logic [N_OUT-1:0][N_IN-1:0]    conn_q;
  logic [N_IN-1:0][FAW:0]        fcnt;

  wire        req_any = avs_read | avs_write;
  wire        wr_fire = avs_write & ack_q;
  wire [9:0]  r_off   = avs_address - SXB_REG_ROUTE_BASE;
  wire [3:0]  r_idx   = r_off[7:4];
  wire [1:0]  r_word  = r_off[3:2];
  wire        r_hit   = (avs_address >= SXB_REG_ROUTE_BASE) && (r_off[9:4] < N_OUT);
  wire [9:0]  f_off   = avs_address - SXB_REG_FCNT_BASE;
  wire [7:0]  f_idx   = f_off[9:2];
  wire        f_hit   = (avs_address >= SXB_REG_FCNT_BASE) && (f_idx < N_IN);
  wire        prio_m  = ctrl_q[SXB_CTRL_PRIO];
  wire        pkt_m   = ctrl_q[SXB_CTRL_PKT];
  wire        last_m  = ctrl_q[SXB_CTRL_LAST];
  wire [31:0] wr_err  = be_merge(32'h0, avs_writedata, avs_byteenable);

  assign avs_waitrequest = req_any & ~ack_q;
  assign avs_readdata    = rd_q;
  assign err_flags       = err_q;

  always_comb begin
    rd_d = 32'h0;
    if (avs_address == SXB_REG_CTRL) rd_d = ctrl_q;
    else if (avs_address == SXB_REG_ARB_CNT) rd_d = 32'(cnt_lim_q);
    else if (avs_address == SXB_REG_ARB_IDLE) rd_d = 32'(idle_lim_q);
    else if (avs_address == SXB_REG_ERR) rd_d = 32'(err_q);
    else if (r_hit && r_word == SXB_ROUTE_LO) rd_d = 32'(lo_q[r_idx]);
    else if (r_hit && r_word == SXB_ROUTE_HI) rd_d = 32'(hi_q[r_idx]);
    else if (r_hit && r_word == SXB_ROUTE_CONN) rd_d = 32'(conn_q[r_idx]);
    else if (f_hit) rd_d = 32'(fcnt[f_idx]);
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ack_q <= 1'b0;
      rd_q  <= 32'h0;
    end else begin
      ack_q <= req_any & ~ack_q;
      if (req_any && !ack_q) rd_q <= rd_d;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_q     <= SXB_CTRL_RST;
      cnt_lim_q  <= SXB_ARB_CNT_RST;
      idle_lim_q <= SXB_ARB_IDLE_RST;
      err_q      <= '0;
      for (int o = 0; o < N_OUT; o++) begin
        lo_q[o]   <= DESTW'(o);
        hi_q[o]   <= DESTW'(o);
        conn_q[o] <= '1;
      end
    end else begin
      // Hardware set wins over a same-cycle write-one clear
      err_q <= (err_q & ~(wr_fire && avs_address == SXB_REG_ERR ?
                          wr_err[SXB_ERRW-1:0] : '0)) | err_set;
      if (wr_fire) begin
        if (avs_address == SXB_REG_CTRL)
          ctrl_q <= be_merge(ctrl_q, avs_writedata, avs_byteenable);
        if (avs_address == SXB_REG_ARB_CNT)
          cnt_lim_q <= SXB_CNTW'(be_merge(32'(cnt_lim_q), avs_writedata, avs_byteenable));
        if (avs_address == SXB_REG_ARB_IDLE)
          idle_lim_q <= SXB_CNTW'(be_merge(32'(idle_lim_q), avs_writedata, avs_byteenable));
        for (int o = 0; o < N_OUT; o++) begin
          if (r_hit && r_idx == 4'(o)) begin
            if (r_word == SXB_ROUTE_LO)
              lo_q[o] <= DESTW'(be_merge(32'(lo_q[o]), avs_writedata, avs_byteenable));
            if (r_word == SXB_ROUTE_HI)
              hi_q[o] <= DESTW'(be_merge(32'(hi_q[o]), avs_writedata, avs_byteenable));
            if (r_word == SXB_ROUTE_CONN)
              conn_q[o] <= N_IN'(be_merge(32'(conn_q[o]), avs_writedata, avs_byteenable));
          end
        end
      end
    end
  end

  // ==========================================================================
  // Input side: slice, FIFO, destination decode
  logic [N_IN-1:0][PW-1:0]      head_pl;
  logic [N_IN-1:0]              head_v;
  logic [N_IN-1:0]              head_rdy;
  logic [N_IN-1:0]              miss;
  logic [N_IN-1:0][N_OUT-1:0]   hit;
  logic [N_OUT-1:0][N_IN-1:0]   take;
  logic [N_IN-1:0][SXB_ERRW-1:0] err_in;

  always_comb begin
    err_set = '0;
    for (int i = 0; i < N_IN; i++) err_set = err_set | err_in[i];
  end

  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_in
      logic [PW-1:0] mem [FIFO_DEPTH];
      logic [FAW:0]  wp_q;
      logic [FAW:0]  rp_q;
      logic [FAW:0]  pk_q;
      logic [PW-1:0] sl_pl;
      logic          sl_v;
      logic          ir;
      logic          take_any;
      // Sideband left unused by a port is tied off at its input
      wire [PW-1:0]  in_pl = {s_tlast[gi], s_tuser[gi*UW +: UW], s_tid[gi*IDW +: IDW],
                              s_tdest[gi*DESTW +: DESTW], s_tkeep[gi*KW +: KW],
                              s_tstrb[gi*KW +: KW], s_tdata[gi*DW +: DW]};
      wire           full  = fcnt[gi] == (FAW+1)'(FIFO_DEPTH);
      wire           empty = fcnt[gi] == '0;
      wire           push  = sl_v & ~full;
      wire           pop   = head_v[gi] & head_rdy[gi];
      wire           in_last = sl_pl[P_LAST];
      wire           hd_last = head_pl[gi][P_LAST];
      wire [KW-1:0]  hd_keep = head_pl[gi][P_KEEP +: KW];
      wire [DESTW-1:0] hd_dest = head_pl[gi][P_DEST +: DESTW];

      assign s_tready[gi] = ir & s_aclken[gi];
      assign fcnt[gi]     = wp_q - rp_q;
      assign fifo_count[gi*(FAW+1) +: FAW+1] = fcnt[gi];
      assign head_pl[gi]  = mem[rp_q[FAW-1:0]];
      // Packets longer than the FIFO never release in packet mode
      assign head_v[gi]   = ~empty & (~pkt_m | pk_q != '0);

      sxb_slice #(.W(PW), .EN(REG_IN)) u_in (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .flush     (~s_aresetn[gi]),
        .in_valid  (s_tvalid[gi] & s_aclken[gi]),
        .in_ready  (ir),
        .in_data   (in_pl),
        .out_valid (sl_v),
        .out_ready (~full),
        .out_data  (sl_pl)
      );

      for (genvar go = 0; go < N_OUT; go++) begin : g_dec
        assign hit[gi][go] = hd_dest >= lo_q[go] && hd_dest <= hi_q[go]
                             && conn_q[go][gi];
      end

      always_comb begin
        take_any = 1'b0;
        for (int o = 0; o < N_OUT; o++) take_any = take_any | take[o][gi];
      end

      // A destination miss is consumed and dropped so it cannot block the port
      assign miss[gi]     = head_v[gi] & ~|hit[gi];
      assign head_rdy[gi] = miss[gi] | take_any;
      assign err_in[gi]   = {pop & (hd_keep == '0) & ~hd_last,
                             pop & keep_sparse(hd_keep),
                             miss[gi]};

      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          wp_q <= '0;
          rp_q <= '0;
          pk_q <= '0;
        end else if (!s_aresetn[gi]) begin
          wp_q <= '0;
          rp_q <= '0;
          pk_q <= '0;
        end else begin
          if (push) begin
            mem[wp_q[FAW-1:0]] <= sl_pl;
            wp_q <= wp_q + (FAW+1)'(1);
          end
          if (pop) rp_q <= rp_q + (FAW+1)'(1);
          pk_q <= pk_q + (FAW+1)'(push & in_last) - (FAW+1)'(pop & hd_last);
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Output side: arbiter per output, then output slice
  genvar go2;
  generate
    for (go2 = 0; go2 < N_OUT; go2++) begin : g_out
      sxb_arb_t            st_q;
      logic [OIW-1:0]      own_q;
      logic [SXB_CNTW-1:0] beats_q;
      logic [SXB_CNTW-1:0] idle_q;
      logic [N_IN-1:0]     req;
      logic                os_rdy;
      logic [PW-1:0]       opl;
      logic [PW-1:0]       cur_pl;
      logic                cur_v;

      for (genvar i2 = 0; i2 < N_IN; i2++) begin : g_req
        assign req[i2] = head_v[i2] & hit[i2][go2];
        assign take[go2][i2] = (st_q == SXB_ARB_HOLD) & (own_q == OIW'(i2))
                               & req[i2] & os_rdy;
      end

      assign cur_v  = (st_q == SXB_ARB_HOLD) & req[own_q];
      assign cur_pl = head_pl[own_q];
      wire   fire   = cur_v & os_rdy;
      wire   end_last = fire & cur_pl[P_LAST] & last_m;
      wire   end_cnt  = fire & (cnt_lim_q != '0) & (beats_q + SXB_CNTW'(1) == cnt_lim_q);
      // Suppress: holder with nothing to send gives the output up
      wire   end_idle = ~cur_v & (idle_q + SXB_CNTW'(1) >= idle_lim_q);
      wire   done   = end_last | end_cnt | end_idle;

      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          st_q    <= SXB_ARB_IDLE;
          own_q   <= '0;
          beats_q <= '0;
          idle_q  <= '0;
        end else begin
          unique case (st_q)
            SXB_ARB_IDLE: begin
              beats_q <= '0;
              idle_q  <= '0;
              if (|req) begin
                own_q <= pick(req, own_q, prio_m);
                st_q  <= SXB_ARB_HOLD;
              end
            end
            SXB_ARB_HOLD: begin
              beats_q <= beats_q + SXB_CNTW'(fire);
              idle_q  <= cur_v ? '0 : idle_q + SXB_CNTW'(1);
              if (done) st_q <= SXB_ARB_IDLE;
            end
          endcase
        end
      end

      sxb_slice #(.W(PW), .EN(REG_OUT)) u_out (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .flush     (~m_aresetn[go2]),
        .in_valid  (cur_v),
        .in_ready  (os_rdy),
        .in_data   (cur_pl),
        .out_valid (m_tvalid[go2]),
        .out_ready (m_tready[go2] & m_aclken[go2]),
        .out_data  (opl)
      );

      assign m_tdata[go2*DW +: DW]       = opl[DW-1:0];
      assign m_tstrb[go2*KW +: KW]       = opl[P_STRB +: KW];
      assign m_tkeep[go2*KW +: KW]       = opl[P_KEEP +: KW];
      assign m_tdest[go2*DESTW +: DESTW] = opl[P_DEST +: DESTW];
      assign m_tid[go2*IDW +: IDW]       = opl[P_ID +: IDW];
      assign m_tuser[go2*UW +: UW]       = opl[P_USER +: UW];
      assign m_tlast[go2]                = opl[P_LAST];
    end
  endgenerate

  // Unrelated port clocks must be bridged before these ports

endmodule : sxb_switch
`default_nettype wire

/* bench/sxb_chk.sv */
// Port-level assertion checker for the stream crossbar switch
`timescale 1ns/10ps
`default_nettype none
module sxb_chk
  import sxb_pkg::*;
#(
  parameter int unsigned N_IN       = 4,
  parameter int unsigned N_OUT      = 4,
  parameter int unsigned DW         = 32,
  parameter int unsigned FIFO_DEPTH = 16
) (
  input wire logic                                ref_clk,
  input wire logic                                reset,
  input wire logic [SXB_AW-1:0]                   avs_address,
  input wire logic                                avs_read,
  input wire logic                                avs_write,
  input wire logic [31:0]                         avs_readdata,
  input wire logic                                avs_waitrequest,
  input wire logic [N_IN-1:0]                     s_aclken,
  input wire logic [N_IN-1:0]                     s_tready,
  input wire logic [N_OUT-1:0]                    m_aresetn,
  input wire logic [N_OUT-1:0]                    m_aclken,
  input wire logic [N_OUT-1:0]                    m_tvalid,
  input wire logic [N_OUT-1:0]                    m_tready,
  input wire logic [N_OUT*DW-1:0]                 m_tdata,
  input wire logic [SXB_ERRW-1:0]                 err_flags,
  input wire logic [N_IN*($clog2(FIFO_DEPTH)+1)-1:0] fifo_count
);
  localparam int CW = $clog2(FIFO_DEPTH) + 1;
  // ==========================================================================
  // Properties
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held past one wait state");
  a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high without a request");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 10'h3f0
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_out_hold: assert property (m_aresetn[0] && m_tvalid[0] && !(m_tready[0] && m_aclken[0])
    |=> m_tvalid[0] && $stable(m_tdata[DW-1:0])) else $error("output beat changed while stalled");
  a_ready_gated: assert property (!s_aclken[0] |-> !s_tready[0])
    else $error("ready high with clock enable low");
  a_err_sticky: assert property (err_flags[0] && !(avs_write && avs_address == SXB_REG_ERR)
    |=> err_flags[0]) else $error("error flag lost without a clear");
  a_quiet_start: assert property ($fell(reset) |-> (m_tvalid == '0) [*3])
    else $error("output valid too soon after reset");
  a_count_max: assert property (fifo_count[CW-1:0] <= FIFO_DEPTH)
    else $error("fifo count above depth");
endmodule : sxb_chk
bind sxb_switch sxb_chk #(.N_IN(N_IN), .N_OUT(N_OUT), .DW(DW), .FIFO_DEPTH(FIFO_DEPTH))
  i_chk (.ref_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .s_aclken, .s_tready, .m_aresetn, .m_aclken, .m_tvalid, .m_tready,
  .m_tdata, .err_flags, .fifo_count);
`default_nettype wire

/* bench/sxb_sink.sv */
// Stream sink endpoints for all outputs, prompt or stalling every other cycle
`timescale 1ns/10ps
`default_nettype none
module sxb_sink #(
  parameter int unsigned N  = 4,
  parameter int unsigned DW = 32
) (
  input wire logic          ref_clk,
  input wire logic          slow,
  input wire logic [N-1:0]  valid,
  output logic [N-1:0]      ready,
  input wire logic [N*DW-1:0] data,
  input wire logic [N-1:0]  last,
  input wire logic [N*4-1:0] tag
);
  // Beats land here as index, last, folded sideband and data
  logic [DW+12:0] got_q[$];
  logic [N-1:0]   ph_q = '0;
  assign ready = slow ? ph_q : '1;
  always @(posedge ref_clk) begin
    ph_q <= ~ph_q;
    for (int o = 0; o < N; o++) begin
      if (valid[o] && ready[o])
        got_q.push_back({8'(o), last[o], tag[o*4 +: 4], data[o*DW +: DW]});
    end
  end
endmodule : sxb_sink
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the stream crossbar switch
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sxb_pkg::*;
  logic ref_clk = 1'b0, reset = 1'b1, slow = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [SXB_AW-1:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, q;
  logic [3:0] avs_byteenable = 4'hf, s_aresetn = '1, s_aclken = '0, s_tvalid = '0;
  logic [3:0] s_tlast = '0, s_tready, m_aresetn = '1, m_aclken = '1, m_tvalid, m_tready, m_tlast;
  logic [127:0] s_tdata = '0, m_tdata;
  logic [15:0] s_tstrb = '1, s_tkeep = '1, s_tdest = '0, s_tid = '0, s_tuser = '0;
  logic [15:0] m_tstrb, m_tkeep, m_tdest, m_tid, m_tuser;
  logic [2:0] err_flags;
  logic [19:0] fifo_count;
  int err_total = 0, cmp_count = 0, cyc = 0;
  sxb_switch i_dut (.ref_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest(), .s_aresetn, .s_aclken, .s_tvalid,
    .s_tready, .s_tdata, .s_tstrb, .s_tkeep, .s_tlast, .s_tdest, .s_tid, .s_tuser, .m_aresetn,
    .m_aclken, .m_tvalid, .m_tready, .m_tdata, .m_tstrb, .m_tkeep, .m_tlast, .m_tdest, .m_tid,
    .m_tuser, .err_flags, .fifo_count);
  // Sideband folds to the destination only when it passes intact
  sxb_sink i_snk (.ref_clk, .slow, .valid(m_tvalid), .ready(m_tready), .data(m_tdata),
    .last(m_tlast), .tag(m_tdest ^ m_tid ^ ~m_tuser ^ ~m_tkeep ^ ~m_tstrb));
  // ==========================================================================
  // Clock, timeout and tasks
  initial forever #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic check(string what, logic [44:0] exp, logic [44:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic bus(logic wr, logic [9:0] a, logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge ref_clk); while (i_dut.avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  task automatic rchk(logic [9:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check("register", {8'h0, e}, {8'h0, q});
  endtask : rchk
  task automatic send(int p, logic [3:0] dst, logic [31:0] d, logic lst, logic [3:0] kp);
    s_tdata[p*32 +: 32] <= d;
    s_tdest[p*4 +: 4] <= dst;
    s_tid[p*4 +: 4] <= dst;
    s_tuser[p*4 +: 4] <= ~dst;
    s_tkeep[p*4 +: 4] <= kp;
    s_tstrb[p*4 +: 4] <= kp;
    s_tlast[p] <= lst;
    s_tvalid[p] <= 1'b1;
    do @(posedge ref_clk); while (s_tready[p] !== 1'b1);
    s_tvalid[p] <= 1'b0;
    s_tdata[p*32 +: 32] <= ~d;
    @(posedge ref_clk);
  endtask : send
  task automatic expb(logic [7:0] o, logic [31:0] d, logic lst = 1'b1, logic [3:0] dst = 4'h0);
    int n = 0;
    while (i_snk.got_q.size() == 0 && n < 60) begin
      @(posedge ref_clk);
      n++;
    end
    check("beat", {o, lst, ((dst != 4'h0) ? dst : o[3:0]), d},
          i_snk.got_q.size() > 0 ? i_snk.got_q.pop_front() : 45'hx);
  endtask : expb
  // ==========================================================================
  // Tests
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (3) @(posedge ref_clk);
    s_aclken <= '1;
    rchk(SXB_REG_CTRL, 32'h4);
    rchk(SXB_REG_ARB_CNT, 32'h0);
    rchk(SXB_REG_ARB_IDLE, 32'h10);
    rchk(10'h060, 32'h2);
    rchk(10'h3f0, 32'h0);
    $display("Test registers done");
    slow <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      send(p, 4'(3 - p), 32'h100 + p, 1'b1, 4'hf);
      expb(8'(3 - p), 32'h100 + p);
    end
    bus(1'b1, 10'h070, 32'h5);
    bus(1'b1, 10'h074, 32'h9);
    send(0, 4'h7, 32'ha5, 1'b1, 4'hf);
    expb(8'h3, 32'ha5, 1'b1, 4'h7);
    bus(1'b1, 10'h048, 32'he);
    send(1, 4'h4, 32'h1, 1'b1, 4'hf);
    send(0, 4'h0, 32'h2, 1'b1, 4'hf);
    send(1, 4'h0, 32'h3, 1'b1, 4'hf);
    expb(8'h0, 32'h3);
    check("dropped", 40'h0, 40'(i_snk.got_q.size()));
    rchk(SXB_REG_ERR, 32'h1);
    bus(1'b1, SXB_REG_ERR, 32'h7);
    send(2, 4'h2, 32'h4, 1'b1, 4'b0010);
    repeat (10) @(posedge ref_clk);
    rchk(SXB_REG_ERR, 32'h2);
    bus(1'b1, SXB_REG_ERR, 32'h7);
    send(2, 4'h2, 32'h5, 1'b0, 4'h0);
    repeat (10) @(posedge ref_clk);
    rchk(SXB_REG_ERR, 32'h4);
    $display("Test routing and errors done");
    i_snk.got_q.delete();
    slow <= 1'b0;
    bus(1'b1, SXB_REG_CTRL, 32'h6);
    send(0, 4'h1, 32'h10, 1'b0, 4'hf);
    send(0, 4'h1, 32'h11, 1'b0, 4'hf);
    repeat (10) @(posedge ref_clk);
    check("held", 40'h0, 40'(i_snk.got_q.size()));
    check("count", 40'h2, 40'(fifo_count[4:0]));
    rchk(SXB_REG_FCNT_BASE, 32'h2);
    send(0, 4'h1, 32'h12, 1'b1, 4'hf);
    for (int k = 0; k < 3; k++) expb(8'h1, 32'h10 + k, k == 2);
    s_aresetn <= 4'he;
    m_aresetn <= 4'hd;
    @(posedge ref_clk);
    s_aresetn <= '1;
    m_aresetn <= '1;
    send(0, 4'h1, 32'h20, 1'b1, 4'hf);
    expb(8'h1, 32'h20);
    $display("Test packet mode and port reset done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
